/* logic/gps_pkg.sv */
// Constants, register layouts and state type of the generator supervisor
package gps_pkg;
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYC_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TW = 16;
  localparam int NPROT = 5;
  localparam int P_FOV = 0;
  localparam int P_GOV = 1;
  localparam int P_OT = 2;
  localparam int P_LOS = 3;
  localparam int P_FCL = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_UNLOAD = 8'h04;
  localparam logic [7:0] OFF_KNEE = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'h0C;
  localparam logic [7:0] OFF_TIMES = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int SEC_MS = 1000;
  localparam int FOV_DLY_MS = 15000;
  localparam int GOV_DLY_MS = 750;
  localparam int BOOT_FLASH_MS = 5000;
  localparam int CROWBAR_MS = 1500;
  localparam int BLINK_MS = 250;
  localparam int OT_C = 70;
  localparam int LOS_1PH_PCT = 50;
  localparam int IMBAL_PCT = 20;
  localparam int PHASE_DEAD_PCT = 0;
  localparam int SC_CT_X10 = 150;
  localparam int LOS_MIN_FX10 = 120;
  localparam int UNL_STEP_X10 = 15;
  localparam int FULL_PCT = 100;
  localparam int UNL_FREQ_MIN = 9;
  localparam int UNL_FREQ_MAX = 90;
  localparam int DROOP_MIN = 1;
  localparam int DROOP_MAX = 20;
  localparam int DTIME_MIN = 1;
  localparam int DTIME_MAX = 5;
  localparam int KNEE_MIN = 400;
  localparam int KNEE_MAX = 650;
  localparam int FCL_MAX = 75;
  localparam int FCL_DLY_MAX = 10;
  localparam int LOS_DLY_MAX = 25;
  localparam int SS_MIN = 1;
  localparam int SS_MAX = 120;

  typedef enum logic [1:0] {
    GPS_RUN = 2'b00,
    GPS_TRIP = 2'b01,
    GPS_CROWBAR = 2'b11
  } gps_mode_e;

  typedef struct packed {
    logic [29:0] rsv; logic three_ph; logic fov_en;
  } gps_ctrl_s;
  typedef struct packed {
    logic [4:0] rsv3; logic [2:0] dtime; logic [2:0] rsv2; logic [4:0] pct;
    logic [7:0] rate; logic rsv1; logic [6:0] freq;
  } gps_unl_s;
  typedef struct packed {logic [21:0] rsv; logic [9:0] knee;} gps_knee_s;
  typedef struct packed {
    logic [3:0] rsv2; logic [3:0] fcl_dly; logic rsv1; logic [6:0] fcl;
    logic [7:0] gov; logic [7:0] fov;
  } gps_lim_s;
  typedef struct packed {
    logic [16:0] rsv2; logic [6:0] ss; logic [2:0] rsv1; logic [4:0] los_dly;
  } gps_tm_s;
  typedef struct packed {
    logic [16:0] rsv; logic [2:0] boot_cause; logic [2:0] cause;
    logic crowbar; logic shut; logic ss; logic unl; logic [4:0] act;
  } gps_stat_s;

  typedef struct packed {
    logic [9:0] freq_x10; logic [7:0] rate_x10; logic [7:0] field_v;
    logic [6:0] field_i_x10; logic [7:0] gen_v_pct; logic [7:0] ph_a_pct;
    logic [7:0] ph_b_pct; logic [7:0] ph_c_pct; logic [7:0] ct_b_x10;
    logic [7:0] temp_c; logic sense_cont; logic gate_pulse;
    logic uf_active; logic [7:0] uf_ref_pct;
  } gps_meas_s;

  localparam gps_ctrl_s CTRL_RST = '{rsv: '0, three_ph: 1'b0, fov_en: 1'b1};
  localparam gps_unl_s UNL_RST = '{dtime: 3'h1, pct: 5'h0A, rate: 8'h01,
                                   freq: 7'h09, default: '0};
  localparam gps_knee_s KNEE_RST = '{rsv: '0, knee: 10'h24E};
  localparam gps_lim_s LIM_RST = '{fcl_dly: 4'hA, fcl: 7'h41, gov: 8'h78,
                                   fov: 8'h50, default: '0};
  localparam gps_tm_s TM_RST = '{ss: 7'h07, los_dly: 5'h05, default: '0};

  typedef struct packed {
    logic pready; logic pslverr; logic [31:0] prdata;
    gps_ctrl_s ctrl; gps_unl_s unl; gps_knee_s knee; gps_lim_s lim;
    gps_tm_s tm; logic [TW-1:0] tick_cnt; logic [NPROT-1:0][TW-1:0] tmr;
    gps_mode_e mode; logic [2:0] cause; logic [TW-1:0] cw_cnt;
    logic crowbar; logic relay; logic booted; logic [2:0] boot_cause;
    logic [TW-1:0] boot_cnt; logic nv_wr_en; logic [2:0] nv_wr_cause;
    logic [TW-1:0] blink_cnt; logic blink; logic [NPROT-1:0] led;
    logic [NPROT-1:0] act; logic unl_on; logic unl_done;
    logic [TW-1:0] unl_cnt; logic [5:0] ustep; logic ss_on;
    logic [TW-1:0] ss_cnt; logic [7:0] ramp; logic [7:0] vref;
    logic shut; logic gate;
  } gps_state_s;

  localparam gps_state_s ST_RST = '{ctrl: CTRL_RST, unl: UNL_RST,
                                    knee: KNEE_RST, lim: LIM_RST,
                                    tm: TM_RST, mode: GPS_RUN,
                                    ss_on: 1'b1, gate: 1'b1, default: '0};
endpackage

/* logic/gps_supervisor.sv */
// Protection, unloading and soft-start supervisor with APB registers
`timescale 1ns/10ps
// Operation
// - Unload when far below knee and falling fast
// - Unload offset 0.9 to 9.0 Hz, default 0.9
// - Unload rate 0 to 25.5, strictly exceeded
// - Setpoint drops percent per 1.5% frequency
// - Unloading ends after 1 to 5 seconds
// - Each protection drives indicator and status
// - Field overvoltage flashes, trips after 15 s
// - Flash last shutdown cause 5 s at power-up, except overtemperature
// - Generator overvoltage 0.75 s trips the unit
// - Above 70 C trips the unit
// - Single phase below 50 percent is loss
// - Three phase dead or 20% imbalance
// - Loss acted on after delay, continuity immediate
// - Loss of sensing flashes, relay, shutdown
// - Loss inhibited: soft start, 12 Hz, short
// - Field current limit with delayed trip
// - Overvoltage without gating 1.5 s fires crowbar
// - Soft start 1 to 120 s, default 7
// - Underfrequency reference overrides soft start ramp
// - Knee 40 to 65 Hz, default 59
// - Alarm relay follows condition, no latch
module gps_supervisor #(
  parameter int TICK_CYC = gps_pkg::TICK_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gps_pkg::gps_meas_s meas,
  input wire logic [2:0] nv_cause_in,
  output logic nv_wr_en,
  output logic [2:0] nv_wr_cause,
  output logic [4:0] ind_led,
  output logic alarm_relay,
  output logic shutdown,
  output logic gate_enable,
  output logic crowbar_fire,
  output logic unload_active,
  output logic [7:0] vref_pct
);
  gps_pkg::gps_state_s s;
  gps_pkg::gps_state_s n;

  // Clamp keeps written settings inside their legal span
  function automatic int clp(input int v, input int lo, input int hi);
    clp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    logic tick;
    logic setup;
    logic wr;
    logic hit;
    logic los_raw;
    logic los_inh;
    logic [2:0] fc;
    logic [4:0] cond;
    logic [4:0] trip;
    logic [4:0][gps_pkg::TW-1:0] lim;
    logic [7:0] mx;
    logic [7:0] mn;
    logic [31:0] rd;
    gps_pkg::gps_stat_s st;
    int dev;
    int hi_t;
    int lo_t;
    int drop;
    int base;
    tick = 1'b0;
    setup = 1'b0;
    wr = 1'b0;
    hit = 1'b0;
    los_raw = 1'b0;
    los_inh = 1'b0;
    fc = 3'h0;
    cond = 5'h00;
    trip = 5'h00;
    lim = '0;
    mx = 8'h00;
    mn = 8'h00;
    rd = 32'h00000000;
    st = '0;
    dev = 0;
    hi_t = 0;
    lo_t = 0;
    drop = 0;
    base = 0;
    n = s;
    n.nv_wr_en = 1'b0;

    // Millisecond timebase; all protection timers count these ticks
    tick = (s.tick_cnt == gps_pkg::TW'(TICK_CYC - 1));
    n.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;

    // No wait states: pready rises in the first access cycle
    setup = psel & ~penable;
    wr = psel & penable & s.pready & pwrite & ~s.pslverr;
    st.act = s.act;
    st.unl = s.unl_on;
    st.ss = s.ss_on;
    st.shut = (s.mode != gps_pkg::GPS_RUN);
    st.crowbar = s.crowbar;
    st.cause = s.cause;
    st.boot_cause = s.boot_cause;
    hit = 1'b1;
    case (paddr)
      gps_pkg::OFF_CTRL: rd = s.ctrl;
      gps_pkg::OFF_UNLOAD: rd = s.unl;
      gps_pkg::OFF_KNEE: rd = s.knee;
      gps_pkg::OFF_LIMIT: rd = s.lim;
      gps_pkg::OFF_TIMES: rd = s.tm;
      gps_pkg::OFF_STATUS: rd = st;
      default: hit = 1'b0;
    endcase
    // Unmapped addresses answer with an error and read as zero
    n.pready = setup;
    n.pslverr = setup & ~hit;
    // Address is taken in setup; prdata holds until the next one
    if (setup) begin
      n.prdata = hit ? rd : 32'h00000000;
    end
    if (wr) begin
      case (paddr)
        gps_pkg::OFF_CTRL: begin
          n.ctrl.fov_en = pwdata[0];
          n.ctrl.three_ph = pwdata[1];
        end
        gps_pkg::OFF_UNLOAD: begin
          n.unl.freq = 7'(clp(int'(pwdata[6:0]), gps_pkg::UNL_FREQ_MIN,
                              gps_pkg::UNL_FREQ_MAX));
          n.unl.rate = pwdata[15:8];
          n.unl.pct = 5'(clp(int'(pwdata[20:16]), gps_pkg::DROOP_MIN,
                             gps_pkg::DROOP_MAX));
          n.unl.dtime = 3'(clp(int'(pwdata[26:24]), gps_pkg::DTIME_MIN,
                               gps_pkg::DTIME_MAX));
        end
        gps_pkg::OFF_KNEE: begin
          n.knee.knee = 10'(clp(int'(pwdata[9:0]), gps_pkg::KNEE_MIN,
                                gps_pkg::KNEE_MAX));
        end
        gps_pkg::OFF_LIMIT: begin
          n.lim.fov = pwdata[7:0];
          n.lim.gov = pwdata[15:8];
          n.lim.fcl = 7'(clp(int'(pwdata[22:16]), 0, gps_pkg::FCL_MAX));
          n.lim.fcl_dly = 4'(clp(int'(pwdata[27:24]), 0,
                                 gps_pkg::FCL_DLY_MAX));
        end
        gps_pkg::OFF_TIMES: begin
          n.tm.los_dly = 5'(clp(int'(pwdata[4:0]), 0, gps_pkg::LOS_DLY_MAX));
          n.tm.ss = 7'(clp(int'(pwdata[14:8]), gps_pkg::SS_MIN,
                           gps_pkg::SS_MAX));
        end
        default: ;
      endcase
    end

    cond[gps_pkg::P_FOV] = s.ctrl.fov_en & (meas.field_v > s.lim.fov);
    cond[gps_pkg::P_GOV] = meas.gen_v_pct > s.lim.gov;
    cond[gps_pkg::P_OT] = int'(meas.temp_c) > gps_pkg::OT_C;
    mx = (meas.ph_a_pct > meas.ph_b_pct) ? meas.ph_a_pct : meas.ph_b_pct;
    mx = (meas.ph_c_pct > mx) ? meas.ph_c_pct : mx;
    mn = (meas.ph_a_pct < meas.ph_b_pct) ? meas.ph_a_pct : meas.ph_b_pct;
    mn = (meas.ph_c_pct < mn) ? meas.ph_c_pct : mn;
    if (s.ctrl.three_ph) begin
      los_raw = (int'(mn) <= gps_pkg::PHASE_DEAD_PCT) |
                (int'(mx) - int'(mn) > gps_pkg::IMBAL_PCT);
    end else begin
      los_raw = int'(meas.gen_v_pct) < gps_pkg::LOS_1PH_PCT;
    end
    los_inh = s.ss_on | (int'(meas.freq_x10) < gps_pkg::LOS_MIN_FX10) |
              (int'(meas.ct_b_x10) > gps_pkg::SC_CT_X10);
    // declared loss joins the trip set
    cond[gps_pkg::P_LOS] = los_raw & ~los_inh;
    cond[gps_pkg::P_FCL] = meas.field_i_x10 > s.lim.fcl;

    lim[gps_pkg::P_FOV] = gps_pkg::TW'(gps_pkg::FOV_DLY_MS);
    lim[gps_pkg::P_GOV] = gps_pkg::TW'(gps_pkg::GOV_DLY_MS);
    lim[gps_pkg::P_OT] = '0;
    lim[gps_pkg::P_LOS] = meas.sense_cont ?
        gps_pkg::TW'(int'(s.tm.los_dly) * gps_pkg::SEC_MS) : '0;
    lim[gps_pkg::P_FCL] = gps_pkg::TW'(int'(s.lim.fcl_dly) * gps_pkg::SEC_MS);

    // Each timer restarts whenever its condition drops out
    // Timers saturate at their limit so a long fault cannot wrap
    for (int i = 0; i < gps_pkg::NPROT; i++) begin
      if (!cond[i]) begin
        n.tmr[i] = '0;
      end else if (tick && s.tmr[i] < lim[i]) begin
        n.tmr[i] = s.tmr[i] + 1'b1;
      end
      trip[i] = cond[i] & (s.tmr[i] >= lim[i]);
    end
    // Lowest index wins when several trip together
    for (int i = gps_pkg::NPROT - 1; i >= 0; i--) begin
      if (trip[i]) begin
        fc = 3'(i + 1);
      end
    end

    // relay tracks live trip condition
    // Opens again when the fault clears, even while shut down
    n.relay = |trip;

    // Power-up cause capture and flash window
    if (!s.booted) begin
      n.booted = 1'b1;
      // stored cause taken once after reset
      n.boot_cause = nv_cause_in;
      n.boot_cnt = '0;
    end else if (tick && s.boot_cnt < gps_pkg::TW'(gps_pkg::BOOT_FLASH_MS)) begin
      n.boot_cnt = s.boot_cnt + 1'b1;
    end else if (s.boot_cnt >= gps_pkg::TW'(gps_pkg::BOOT_FLASH_MS) &&
                 s.boot_cause != 3'h0) begin
      // Clear the stored cause once shown so it flashes only once
      n.boot_cause = 3'h0;
      n.nv_wr_en = 1'b1;
      n.nv_wr_cause = 3'h0;
    end

    if (s.mode == gps_pkg::GPS_RUN && (|trip)) begin
      n.mode = gps_pkg::GPS_TRIP;
      n.cause = fc;
      n.nv_wr_en = 1'b1;
      n.nv_wr_cause = fc;
    end

    // gating watchdog under field overvoltage
    // Compare ignores the enable: the crowbar always guards the field
    if (meas.gate_pulse || !(meas.field_v > s.lim.fov)) begin
      n.cw_cnt = '0;
    end else if (tick && s.cw_cnt < gps_pkg::TW'(gps_pkg::CROWBAR_MS)) begin
      n.cw_cnt = s.cw_cnt + 1'b1;
    end
    if (s.cw_cnt >= gps_pkg::TW'(gps_pkg::CROWBAR_MS)) begin
      n.crowbar = 1'b1;
      n.mode = gps_pkg::GPS_CROWBAR;
    end
    // no path back to run except reset
    // Registered so the pins carry no decode glitch
    n.shut = (n.mode != gps_pkg::GPS_RUN);
    n.gate = (n.mode == gps_pkg::GPS_RUN);

    // Shared flash phase for every indicator
    if (tick) begin
      if (s.blink_cnt >= gps_pkg::TW'(gps_pkg::BLINK_MS - 1)) begin
        n.blink_cnt = '0;
        n.blink = ~s.blink;
      end else begin
        n.blink_cnt = s.blink_cnt + 1'b1;
      end
    end
    for (int i = 0; i < gps_pkg::NPROT; i++) begin
      n.act[i] = ((i == gps_pkg::P_FOV || i == gps_pkg::P_FCL) ?
                  cond[i] : trip[i]) |
                 ((s.mode != gps_pkg::GPS_RUN) && s.cause == 3'(i + 1));
      n.led[i] = s.blink & (s.act[i] |
                 (s.booted && i != gps_pkg::P_OT &&
                  s.boot_cnt < gps_pkg::TW'(gps_pkg::BOOT_FLASH_MS) &&
                  s.boot_cause == 3'(i + 1)));
    end

    if (!s.unl_on && !s.unl_done &&
        (11'(meas.freq_x10) + 11'(s.unl.freq) <= 11'(s.knee.knee)) &&
        (meas.rate_x10 > s.unl.rate)) begin
      n.unl_on = 1'b1;
      n.unl_cnt = '0;
    end else if (s.unl_on && tick) begin
      if (int'(s.unl_cnt) >= int'(s.unl.dtime) * gps_pkg::SEC_MS - 1) begin
        n.unl_on = 1'b0;
        n.unl_done = 1'b1;
      end else begin
        n.unl_cnt = s.unl_cnt + 1'b1;
      end
    end
    // Rearm only once frequency is back at the knee
    if (!s.unl_on && meas.freq_x10 >= s.knee.knee) begin
      n.unl_done = 1'b0;
    end

    // count 1.5 percent steps below knee
    // One step per cycle keeps a divider out of the path
    if (s.knee.knee > meas.freq_x10) begin
      dev = (int'(s.knee.knee) - int'(meas.freq_x10)) * 1000;
    end
    hi_t = (int'(s.ustep) + 1) * gps_pkg::UNL_STEP_X10 * int'(s.knee.knee);
    lo_t = int'(s.ustep) * gps_pkg::UNL_STEP_X10 * int'(s.knee.knee);
    if (dev >= hi_t && s.ustep != 6'h3F) begin
      n.ustep = s.ustep + 1'b1;
    end else if (dev < lo_t) begin
      n.ustep = s.ustep - 1'b1;
    end
    drop = int'(s.ustep) * int'(s.unl.pct);

    // soft start ramp pacing
    // Ramp holds at full scale once the last step is taken
    if (s.ss_on && tick) begin
      if (int'(s.ss_cnt) >= int'(s.tm.ss) * gps_pkg::SEC_MS /
          gps_pkg::FULL_PCT - 1) begin
        n.ss_cnt = '0;
        n.ramp = s.ramp + 1'b1;
        if (int'(s.ramp) >= gps_pkg::FULL_PCT - 1) begin
          n.ss_on = 1'b0;
        end
      end else begin
        n.ss_cnt = s.ss_cnt + 1'b1;
      end
    end

    base = meas.uf_active ? int'(meas.uf_ref_pct) :
           (s.ss_on ? int'(s.ramp) : gps_pkg::FULL_PCT);
    if (s.unl_on) begin
      base = (base > drop) ? base - drop : 0;
    end
    n.vref = 8'(base);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= gps_pkg::ST_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign nv_wr_en = s.nv_wr_en;
  assign nv_wr_cause = s.nv_wr_cause;
  assign ind_led = s.led;
  assign alarm_relay = s.relay;
  assign shutdown = s.shut;
  assign gate_enable = s.gate;
  assign crowbar_fire = s.crowbar;
  assign unload_active = s.unl_on;
  assign vref_pct = s.vref;
endmodule

/* test/gps_front_end.sv */
// Regulator loop and sensing front end model feeding the supervisor
`timescale 1ns/10ps
module gps_front_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic gating_on,
  input wire logic gate_enable,
  input wire gps_pkg::gps_meas_s base,
  output gps_pkg::gps_meas_s meas
);
  logic [2:0] div_ff;
  logic pulse_ff;
  // Gating stops when the unit is shut down, as the real loop would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 3'h0;
      pulse_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 3'h1;
      pulse_ff <= (div_ff == 3'h7) && gating_on && gate_enable;
    end
  end
  always_comb begin
    meas = base;
    meas.gate_pulse = pulse_ff;
  end
endmodule

/* test/gps_supervisor_checker.sv */
// Port level assertions for the generator supervisor
`timescale 1ns/10ps
module gps_supervisor_checker #(
  parameter int TICK_CYC = gps_pkg::TICK_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire gps_pkg::gps_meas_s meas,
  input wire logic nv_wr_en,
  input wire logic [2:0] nv_wr_cause,
  input wire logic alarm_relay,
  input wire logic shutdown,
  input wire logic gate_enable,
  input wire logic crowbar_fire,
  input wire logic unload_active
);
  // Longest setting plus one partial tick and a little pipeline slack
  localparam int UNL_MAX = 5 * 1000 * TICK_CYC + TICK_CYC + 4;
  logic [31:0] unl_cnt_ff;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_cnt_ff <= 32'h0;
    end else begin
      unl_cnt_ff <= unload_active ? unl_cnt_ff + 32'h1 : 32'h0;
    end
  end
  gate_inv_a: assert property (gate_enable == !shutdown)
    else $error("gate enable not inverse of shutdown");
  shut_hold_a: assert property (shutdown |=> shutdown)
    else $error("shutdown released without power cycle");
  crowbar_shut_a: assert property ($rose(crowbar_fire) |->
    ##[0:1] shutdown) else $error("crowbar fired without shutdown");
  ot_trip_a: assert property (meas.temp_c > 8'h46 |->
    ##[1:2] shutdown) else $error("overtemperature did not shut down");
  ot_relay_a: assert property (meas.temp_c > 8'h46 |->
    ##[1:2] alarm_relay) else $error("overtemperature did not close relay");
  nv_pulse_a: assert property (nv_wr_en |=> !nv_wr_en)
    else $error("store write longer than one cycle");
  nv_cause_a: assert property (nv_wr_en && nv_wr_cause != 3'h0 |->
    ##[0:1] shutdown) else $error("cause stored without shutdown");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside an access");
  unload_len_a: assert property (unl_cnt_ff <= UNL_MAX)
    else $error("unloading lasted too long");
  cover property ($rose(shutdown));
  cover property ($rose(crowbar_fire));
  cover property ($rose(unload_active));
endmodule
bind gps_supervisor gps_supervisor_checker #(.TICK_CYC(TICK_CYC))
  gps_supervisor_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .meas(meas), .nv_wr_en(nv_wr_en), .nv_wr_cause(nv_wr_cause),
  .alarm_relay(alarm_relay), .shutdown(shutdown),
  .gate_enable(gate_enable), .crowbar_fire(crowbar_fire),
  .unload_active(unload_active));

/* test/test_gps_supervisor.sv */
// Self-checking bench for the generator supervisor
`timescale 1ns/10ps
module test_gps_supervisor;
  localparam int TC = 4;
  localparam gps_pkg::gps_meas_s NOM = '{freq_x10: 10'h258,
    field_v: 8'h32, field_i_x10: 7'h1E, gen_v_pct: 8'h64, ph_a_pct: 8'h64,
    ph_b_pct: 8'h64, ph_c_pct: 8'h64, ct_b_x10: 8'h32, temp_c: 8'h19,
    sense_cont: 1'h1, uf_ref_pct: 8'h64, default: '0};
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} gps_row_s;
  gps_row_s rows [6] = '{'{8'h00, 32'h00000001, 1'h0},
    '{8'h04, 32'h010A0109, 1'h0}, '{8'h08, 32'h0000024E, 1'h0},
    '{8'h0C, 32'h0A417850, 1'h0}, '{8'h10, 32'h00000705, 1'h0},
    '{8'h18, 32'h00000000, 1'h1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, vref_pct;
  logic [31:0] pwdata, prdata, rd, last_cause;
  logic [2:0] nv_cause_in, nv_wr_cause;
  logic [4:0] ind_led;
  logic nv_wr_en, alarm_relay, shutdown, gate_enable, crowbar_fire;
  logic unload_active, gating_on;
  gps_pkg::gps_meas_s base, meas;
  int num_errors, samples_checked;
  gps_supervisor #(.TICK_CYC(TC)) gps_supervisor_inst (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .nv_cause_in(nv_cause_in),
    .nv_wr_en(nv_wr_en), .nv_wr_cause(nv_wr_cause), .ind_led(ind_led),
    .alarm_relay(alarm_relay), .shutdown(shutdown),
    .gate_enable(gate_enable), .crowbar_fire(crowbar_fire),
    .unload_active(unload_active), .vref_pct(vref_pct));
  gps_front_end gps_front_end_inst (.pclk(pclk), .presetn(presetn),
    .gating_on(gating_on), .gate_enable(gate_enable), .base(base),
    .meas(meas));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (nv_wr_en === 1'b1) last_cause <= {29'h0, nv_wr_cause};
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chkw(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return shutdown;
      1: return crowbar_fire;
      2: return unload_active;
      default: return ind_led[k-3];
    endcase
  endfunction
  // Bounded poll; running out of time ends the run
  task automatic wait_v(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("wait", v, sig(k));
    if (sig(k) !== v) close_out();
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1'b1, pready);
    if (pready !== 1'b1) close_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic power(input logic [2:0] c);
    presetn <= 1'b0;
    nv_cause_in <= c;
    gating_on <= 1'b1;
    base <= NOM;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    num_errors = 0;
    samples_checked = 0;
    {psel, penable, pwrite, presetn, gating_on} = 5'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    nv_cause_in = 3'h0;
    last_cause = 32'h0;
    base = NOM;
    repeat (6) @(posedge pclk);
    chk("gate", 1'b1, gate_enable);
    chk("shut", 1'b0, shutdown);
    chk("relay", 1'b0, alarm_relay);
    presetn <= 1'b1;
    @(posedge pclk);
    $display("reset done");
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b0, 32'h0);
      chkw("rdata", rows[i].d, rd);
      chk("slverr", rows[i].e, err);
    end
    apb(8'h08, 1'b1, 32'h000003E8);
    apb(8'h08, 1'b0, 32'h0);
    chkw("knee", 32'h0000028A, rd);
    $display("registers done");
    base.temp_c <= 8'h46;
    repeat (10) @(posedge pclk);
    chk("shut", 1'b0, shutdown);
    base.temp_c <= 8'h47;
    wait_v(0, 1'b1, 10);
    repeat (3) @(posedge pclk);
    chk("relay", 1'b1, alarm_relay);
    chk("gate", 1'b0, gate_enable);
    chkw("cause", 32'h3, last_cause);
    apb(8'h14, 1'b0, 32'h0);
    chkw("status", 32'h000006C4, rd);
    base.temp_c <= 8'h19;
    repeat (5) @(posedge pclk);
    chk("relay", 1'b0, alarm_relay);
    chk("shut", 1'b1, shutdown);
    $display("overtemperature done");
    power(3'h2);
    chk("shut", 1'b0, shutdown);
    wait_v(4, 1'b1, 1100);
    base.gen_v_pct <= 8'h79;
    repeat (2950) @(posedge pclk);
    chk("shut", 1'b0, shutdown);
    wait_v(0, 1'b1, 100);
    @(posedge pclk);
    chkw("cause", 32'h2, last_cause);
    $display("overvoltage done");
    power(3'h0);
    base.uf_active <= 1'b1;
    base.uf_ref_pct <= 8'h5A;
    repeat (3) @(posedge pclk);
    chkw("vref", 32'h5A, {24'h0, vref_pct});
    // Underfrequency reference stays on as a fixed base for the droop
    base.freq_x10 <= 10'h246;
    base.rate_x10 <= 8'h02;
    repeat (20) @(posedge pclk);
    chk("unl", 1'b0, unload_active);
    base.freq_x10 <= 10'h245;
    base.rate_x10 <= 8'h01;
    repeat (20) @(posedge pclk);
    chk("unl", 1'b0, unload_active);
    base.rate_x10 <= 8'h02;
    wait_v(2, 1'b1, 5);
    repeat (3980) @(posedge pclk);
    chk("unl", 1'b1, unload_active);
    chkw("vref", 32'h50, {24'h0, vref_pct});
    wait_v(2, 1'b0, 40);
    repeat (2) @(posedge pclk);
    chkw("vref", 32'h5A, {24'h0, vref_pct});
    $display("unloading done");
    power(3'h0);
    apb(8'h10, 1'b1, 32'h00000100);
    base.gen_v_pct <= 8'h28;
    repeat (2000) @(posedge pclk);
    chk("shut", 1'b0, shutdown);
    wait_v(0, 1'b1, 2600);
    @(posedge pclk);
    chkw("cause", 32'h4, last_cause);
    $display("loss of sensing done");
    power(3'h0);
    base.field_v <= 8'h51;
    wait_v(3, 1'b1, 1100);
    apb(8'h00, 1'b1, 32'h0);
    gating_on <= 1'b0;
    repeat (5900) @(posedge pclk);
    chk("crowbar", 1'b0, crowbar_fire);
    wait_v(1, 1'b1, 300);
    chk("shut", 1'b1, shutdown);
    $display("crowbar done");
    close_out();
  end
endmodule
